// ===== verilog/mdsc_defines.svh
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH
// register byte offsets
`define MDSC_OFF_MAIN 8'h00
`define MDSC_OFF_ALARM 8'h04
`define MDSC_OFF_PLL 8'h08
`define MDSC_OFF_REF 8'h0C
`define MDSC_OFF_ALIGN 8'h10
`define MDSC_OFF_GAIN 8'h14
`define MDSC_OFF_CODE 8'h18
`define MDSC_OFF_STAT 8'h1C
// field positions
`define MDSC_MAIN_CLKDIV_ENA 2
`define MDSC_MAIN_DUAL_MODE 0
`define MDSC_PLL_NDIV_ENA 11
`define MDSC_PLL_ENABLE 0
`define MDSC_REF_EXTREF 0
`define MDSC_ALIGN_SRC_OUTPUT_STROBE 0
`define MDSC_ALARM_COLL 0
// reset values
`define MDSC_RST_MAIN 32'h0000_0000
`define MDSC_RST_GAIN 4'hF
// timing: fifo depth, clock divider length and pll divider length
`define MDSC_FIFO_DEPTH 8
`define MDSC_CLKDIV_N 4
`define MDSC_NDIV_N 16
`endif

// ===== verilog/mdsc_pkg.sv
`default_nettype none
package mdsc_pkg;
  typedef enum logic [1:0] {MDSC_SS_SINGLE, MDSC_SS_DUAL_EXT,
    MDSC_SS_DUAL_PLL} mdsc_mode_t;
endpackage : mdsc_pkg
`default_nettype wire

// ===== verilog/mdsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rising-edge pulse from the second stage
module mdsc_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // async level in, synced level and rise out
  input wire logic din,
  output logic dout,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // two flops then an edge flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule : mdsc_sync2
`default_nettype wire

// ===== verilog/mdsc_top.sv
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mdsc_defines.svh"
// Summary of operation
// R1: dual mode reads fifo on output strobe
// R2: fifo absorbs input delay differences
// R3: output strobe sampled on conversion clock
// R4: strobe and clock share one source
// R5: controller selects strobe, then aligns
// R6: controller checks alarm status word
// R7: controller clears clock divider enable
// R8: pll mode makes internal output strobe
// R9: sync rise resets pll dividers
// R10: controller clears pll divider enable
// R11: pll mode needs no sync/frame timing
// R12: controller follows pll alignment order
// R13: single mode resamples write pointer reset
// R14: handoff may shift latency
// R15: pll single mode ignores strobe
// R16: 4-bit coarse gain (code+1)/16
// R17: extref bit selects reference source
// R18: code steers positive/negative outputs
// R19: controller arms divider enable first
// R20: on alarm controller resynchronises
// R21: alignment ignored while enable cleared
module mdsc_top
  import mdsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link pins, asynchronous to clk
  input wire logic data_clk,
  input wire logic [15:0] data_in,
  input wire logic sync_in,
  input wire logic output_strobe,
  // analog controls and output steering
  output logic [3:0] coarse_gain,
  output logic intref_on,
  output logic [15:0] positive_current_output,
  output logic [15:0] negative_current_output,
  output logic alarm_out,
  output logic clkdiv_tick
);
  localparam int DW = 16;
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic dclk_s, dclk_rise, sync_s, sync_rise, output_strobe_s, output_strobe_rise;
  mdsc_sync2 u_dclk (.clk(clk), .nrst(nrst), .din(data_clk),
    .dout(dclk_s), .rise(dclk_rise));
  mdsc_sync2 u_sync (.clk(clk), .nrst(nrst), .din(sync_in),
    .dout(sync_s), .rise(sync_rise));
  mdsc_sync2 u_output_strobe (.clk(clk), .nrst(nrst), .din(output_strobe),
    .dout(output_strobe_s), .rise(output_strobe_rise)); // [R3]
  logic [DW-1:0] din_s1_q, din_s2_q;
  // data word through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] main_q, pll_q, ref_q, align_q;
  logic [3:0] gain_q;
  logic coll_q;
  logic ap_valid_q, ap_write_q;
  logic [7:0] ap_addr_q;
  logic wr_main, wr_pll, wr_alarm;
  // address phase capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_valid_q <= hsel & htrans[1];
      ap_write_q <= hwrite;
      ap_addr_q <= haddr;
    end
  end
  assign wr_main = ap_valid_q & ap_write_q & (ap_addr_q == `MDSC_OFF_MAIN);
  assign wr_pll = ap_valid_q & ap_write_q & (ap_addr_q == `MDSC_OFF_PLL);
  assign wr_alarm = ap_valid_q & ap_write_q & (ap_addr_q == `MDSC_OFF_ALARM);
  // control word writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_q <= `MDSC_RST_MAIN;
      pll_q <= 32'h0000_0000;
      ref_q <= 32'h0000_0000;
      align_q <= 32'h0000_0000;
      gain_q <= `MDSC_RST_GAIN;
    end else if (ap_valid_q && ap_write_q) begin
      if (ap_addr_q == `MDSC_OFF_MAIN) begin
        main_q <= hwdata;
      end else if (ap_addr_q == `MDSC_OFF_PLL) begin
        pll_q <= hwdata;
      end else if (ap_addr_q == `MDSC_OFF_REF) begin
        ref_q <= hwdata;
      end else if (ap_addr_q == `MDSC_OFF_ALIGN) begin
        align_q <= hwdata;
      end else if (ap_addr_q == `MDSC_OFF_GAIN) begin
        gain_q <= hwdata[3:0]; // [R16]
      end
    end
  end
  logic clkdiv_ena, ndiv_ena, dual_mode, pll_on, src_output_strobe;
  assign clkdiv_ena = main_q[`MDSC_MAIN_CLKDIV_ENA];
  assign dual_mode = main_q[`MDSC_MAIN_DUAL_MODE];
  assign ndiv_ena = pll_q[`MDSC_PLL_NDIV_ENA];
  assign pll_on = pll_q[`MDSC_PLL_ENABLE];
  assign src_output_strobe = align_q[`MDSC_ALIGN_SRC_OUTPUT_STROBE];
  mdsc_mode_t mode;
  always_comb begin
    if (!dual_mode) begin
      mode = MDSC_SS_SINGLE;
    end else if (pll_on) begin
      mode = MDSC_SS_DUAL_PLL;
    end else begin
      mode = MDSC_SS_DUAL_EXT;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pll feedback divider and internal output strobe
  logic [3:0] ndiv_q;
  logic int_strobe;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ndiv_q <= 4'h0;
    end else if (sync_rise && ndiv_ena) begin
      ndiv_q <= 4'h0; // [R9] [R21]
    end else begin
      ndiv_q <= ndiv_q + 4'h1;
    end
  end
  assign int_strobe = pll_on && (ndiv_q == 4'hF); // [R8] [R11]
  // strobe source used for divider alignment and fifo read reset
  logic strobe_evt;
  assign strobe_evt = pll_on ? int_strobe : output_strobe_rise;
  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider
  logic [1:0] cdiv_q;
  logic align_evt;
  assign align_evt = src_output_strobe ? strobe_evt : sync_rise;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cdiv_q <= 2'h0;
    end else if (align_evt && clkdiv_ena) begin
      cdiv_q <= 2'h0; // [R21]
    end else begin
      cdiv_q <= cdiv_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // input fifo, written on data clock edges
  logic [DW-1:0] mem [`MDSC_FIFO_DEPTH];
  logic [2:0] wptr_q, rptr_q;
  logic wrst_q, rrst_s1_q, rrst_s2_q;
  // write side, pointer reset by sync
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_q <= 3'h0;
      wrst_q <= 1'b0;
    end else if (dclk_rise) begin
      wrst_q <= sync_s;
      if (sync_s && !wrst_q) begin
        wptr_q <= 3'h0;
      end else begin
        wptr_q <= wptr_q + 3'h1; // [R2]
      end
    end
  end
  // one writer per entry, cleared so reads never show unknown words
  for (genvar g = 0; g < `MDSC_FIFO_DEPTH; g++) begin : g_mem
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        mem[g] <= 16'h0000;
      end else if (dclk_rise && (wptr_q == 3'(g))) begin
        mem[g] <= din_s2_q;
      end
    end
  end
  // handoff of write reset into read domain, may shift latency
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rrst_s1_q <= 1'b0;
      rrst_s2_q <= 1'b0;
    end else begin
      rrst_s1_q <= wrst_q;
      rrst_s2_q <= rrst_s1_q; // [R13] [R14]
    end
  end
  logic rrst_prev_q;
  logic rd_reset, rd_tick;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rrst_prev_q <= 1'b0;
    end else begin
      rrst_prev_q <= rrst_s2_q;
    end
  end
  // read reset source per mode
  always_comb begin
    case (mode)
      MDSC_SS_SINGLE: rd_reset = rrst_s2_q & ~rrst_prev_q; // [R13] [R15]
      default: rd_reset = strobe_evt; // [R1]
    endcase
  end
  assign rd_tick = (cdiv_q == 2'h3);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rptr_q <= 3'h4;
    end else if (rd_reset) begin
      rptr_q <= 3'h4; // [R1] [R2]
    end else if (rd_tick) begin
      rptr_q <= rptr_q + 3'h1;
    end
  end
  // collision alarm, set wins over clear
  logic coll_evt;
  assign coll_evt = dclk_rise && (wptr_q == rptr_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coll_q <= 1'b0;
    end else if (coll_evt) begin
      coll_q <= 1'b1;
    end else if (wr_alarm && !hwdata[`MDSC_ALARM_COLL]) begin
      coll_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      positive_current_output <= 16'h0000;
      negative_current_output <= 16'hFFFF;
      coarse_gain <= `MDSC_RST_GAIN;
      intref_on <= 1'b1;
      alarm_out <= 1'b0;
      clkdiv_tick <= 1'b0;
    end else begin
      if (rd_tick) begin
        positive_current_output <= mem[rptr_q]; // [R18]
        negative_current_output <= ~mem[rptr_q]; // [R18]
      end
      coarse_gain <= gain_q; // [R16]
      intref_on <= ~ref_q[`MDSC_REF_EXTREF]; // [R17]
      alarm_out <= coll_q;
      clkdiv_tick <= rd_tick;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // ahb read data and response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        if (haddr == `MDSC_OFF_MAIN) begin
          hrdata <= main_q;
        end else if (haddr == `MDSC_OFF_ALARM) begin
          hrdata <= {31'h0, coll_q};
        end else if (haddr == `MDSC_OFF_PLL) begin
          hrdata <= pll_q;
        end else if (haddr == `MDSC_OFF_REF) begin
          hrdata <= ref_q;
        end else if (haddr == `MDSC_OFF_ALIGN) begin
          hrdata <= align_q;
        end else if (haddr == `MDSC_OFF_GAIN) begin
          hrdata <= {28'h0, gain_q};
        end else if (haddr == `MDSC_OFF_STAT) begin
          hrdata <= {24'h0, rptr_q, wptr_q, sync_s, output_strobe_s};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end
  logic unused;
  assign unused = &{1'b0, hsize, dclk_s, wr_main, wr_pll};
endmodule : mdsc_top
`default_nettype wire

// ===== verif/mdsc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdsc_defines.svh"
module mdsc_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // controls and outputs
  input wire logic [3:0] coarse_gain,
  input wire logic intref_on,
  input wire logic [15:0] positive_current_output,
  input wire logic [15:0] negative_current_output,
  input wire logic alarm_out,
  input wire logic clkdiv_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr_q;
  logic rd_q;
  logic [7:0] ad_q;
  ////////////////////////////////////////////////////////////////////////
  // data phase tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ad_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      rd_q <= hsel & htrans[1] & ~hwrite;
      ad_q <= haddr;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready)
    else $error("bus wait or error seen");
  property p_comp;
    negative_current_output == ~positive_current_output;
  endproperty
  a_comp: assert property (p_comp)
    else $error("outputs not complementary");
  property p_gain;
    $changed(coarse_gain) |-> $past(wr_q && ad_q == `MDSC_OFF_GAIN, 2)
      && coarse_gain == $past(hwdata[3:0], 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain changed without write");
  property p_ref;
    $changed(intref_on) |-> $past(wr_q && ad_q == `MDSC_OFF_REF, 2)
      && intref_on == !$past(hwdata[0], 2);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference select wrong");
  property p_rdgain;
    rd_q && ad_q == `MDSC_OFF_GAIN |-> hrdata[3:0] == coarse_gain;
  endproperty
  a_rdgain: assert property (p_rdgain)
    else $error("gain readback wrong");
  property p_unmap; rd_q && ad_q == `MDSC_OFF_CODE |-> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_clr;
    $fell(alarm_out) |->
      $past(wr_q && ad_q == `MDSC_OFF_ALARM && !hwdata[0], 2);
  endproperty
  a_clr: assert property (p_clr)
    else $error("alarm cleared without write");
  property p_tick; clkdiv_tick |=> !clkdiv_tick; endproperty
  a_tick: assert property (p_tick)
    else $error("divider tick too long");
  c_gain: cover property ($changed(coarse_gain));
  c_ref: cover property ($fell(intref_on));
  c_tick: cover property (clkdiv_tick);
endmodule : mdsc_top_properties
`default_nettype wire

// ===== verif/mdsc_source.sv
`timescale 1ns/1ps
`default_nettype none
module mdsc_source (
  // system clock
  input wire logic clk,
  // link pins
  output logic data_clk,
  output logic [15:0] data_in,
  output logic sync_in,
  output logic output_strobe
);
  // idle pins
  initial begin
    data_clk = 1'b0;
    data_in = 16'h0000;
    sync_in = 1'b0;
    output_strobe = 1'b0;
  end
  // one word, data clock runs only inside the frame
  task frame(input logic [15:0] w);
    data_in = w;
    #62.5 data_clk = 1'b1;
    #62.5 data_clk = 1'b0;
    data_in = ~w; // released word shows inverse
    @(posedge clk);
  endtask : frame
  // strobe from the system clock domain, sync level
  task pins(input logic s, input logic o);
    @(posedge clk);
    sync_in <= s;
    output_strobe <= o;
    repeat (4) @(posedge clk);
  endtask : pins
endmodule : mdsc_source
`default_nettype wire

// ===== verif/test_multi_dac_sync_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdsc_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_multi_dac_sync_control;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, intref_on, alarm_out;
  logic clkdiv_tick, data_clk, sync_in, output_strobe;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] data_in, positive_current_output, negative_current_output;
  logic [3:0] coarse_gain;
  int bad_count = 0;
  int total_checks = 0;
  // design and link partner
  mdsc_top u_dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .data_clk,
    .data_in, .sync_in, .output_strobe, .coarse_gain, .intref_on,
    .positive_current_output, .negative_current_output, .alarm_out,
    .clkdiv_tick);
  mdsc_source u_src (.clk, .data_clk, .data_in, .sync_in, .output_strobe);
  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // verdict
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // bounded wait for ready
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        bad_count++;
        complete_run();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // bounded wait for a divider tick
  task wait_tick;
    int n;
    n = 0;
    @(posedge clk);
    while (clkdiv_tick !== 1'b1) begin
      n++;
      if (n > 100) begin
        bad_count++;
        complete_run();
      end
      @(posedge clk);
    end
  endtask : wait_tick
  // single word transfer, read data into rd
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  // main sequence
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("gain", 4'hF, coarse_gain)
    `CHK("intref", 1'b1, intref_on)
    `CHK("neg", 16'hFFFF, negative_current_output)
    xfer(1'b0, `MDSC_OFF_GAIN, 32'h0);
    `CHK("gain word", 4'hF, rd[3:0])
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, `MDSC_OFF_GAIN, 32'(i));
      repeat (2) @(posedge clk);
      `CHK("gain", 4'(i), coarse_gain)
    end
    xfer(1'b1, `MDSC_OFF_REF, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("intref", 1'b0, intref_on)
    xfer(1'b1, `MDSC_OFF_REF, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("intref", 1'b1, intref_on)
    xfer(1'b1, `MDSC_OFF_CODE, 32'hFFFF_FFFF);
    xfer(1'b0, `MDSC_OFF_CODE, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // dual mode, strobe aligned divider, link traffic
    xfer(1'b1, `MDSC_OFF_ALIGN, 32'h1);
    xfer(1'b1, `MDSC_OFF_MAIN, 32'h5);
    u_src.pins(1'b1, 1'b1);
    xfer(1'b0, `MDSC_OFF_STAT, 32'h0);
    `CHK("pins high", 2'b11, rd[1:0])
    u_src.pins(1'b0, 1'b0);
    xfer(1'b0, `MDSC_OFF_STAT, 32'h0);
    `CHK("pins low", 2'b00, rd[1:0])
    for (int i = 0; i < 6; i++) u_src.frame(16'hA5C0 + 16'(i));
    xfer(1'b1, `MDSC_OFF_ALARM, 32'h0);
    xfer(1'b0, `MDSC_OFF_ALARM, 32'h0);
    `CHK("alarm word", 1'b0, rd[0])
    `CHK("alarm pin", 1'b0, alarm_out)
    xfer(1'b0, `MDSC_OFF_STAT, 32'h0);
    `CHK("write pointer", 3'h6, rd[4:2])
    // resync of the read side on a fresh strobe
    u_src.pins(1'b0, 1'b1);
    wait_tick();
    `CHK("first word", 16'hA5C4, positive_current_output)
    `CHK("inverse word", 16'h5A3B, negative_current_output)
    u_src.pins(1'b0, 1'b0);
    xfer(1'b1, `MDSC_OFF_MAIN, 32'h1);
    xfer(1'b0, `MDSC_OFF_MAIN, 32'h0);
    `CHK("main word", 3'b001, rd[2:0])
    // pll divider alignment order
    xfer(1'b1, `MDSC_OFF_PLL, 32'h801);
    u_src.pins(1'b1, 1'b0);
    u_src.pins(1'b0, 1'b0);
    xfer(1'b1, `MDSC_OFF_PLL, 32'h1);
    xfer(1'b0, `MDSC_OFF_PLL, 32'h0);
    `CHK("pll word", 12'h001, rd[11:0])
    complete_run();
  end
endmodule : test_multi_dac_sync_control
bind mdsc_top mdsc_top_properties u_props (.clk, .nrst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .coarse_gain, .intref_on, .positive_current_output,
  .negative_current_output, .alarm_out, .clkdiv_tick);
`default_nettype wire
